/* File: rtl/bcr_consts.svh */
// offsets, field positions, reset values and timing counts of the capability block
//
// Behaviour
// [RQ1] capability bit 0 is one exactly when the writable user name string exists
// [RQ2] capability bit 1 is one when keep-alive timer and access privilege exist
// [RQ3] capability bit 2 is one when a separate asynchronous message channel exists
// [RQ4] capability bit 3 is one only when a readable device time counter exists
// [RQ5] bits 7:4 give string encoding: 0 ASCII, 1 UTF-8, 2 UTF-16, never reserved codes
// [RQ6] capability bit 8 is one only when the product-line name string exists
// [RQ7] capability bit 9 is one when a technology-specific register map exists
// [RQ8] capability bit 10 is one exactly when the byte-order register exists
// [RQ9] capability bit 11 is one when write replies carry a written byte count
// [RQ10] capability bit 12 is one when several events fit one event packet
// [RQ11] capability bits 13 through 63 always read as zero
// [RQ12] response time register holds longest command execution time in milliseconds
// [RQ13] a command outlasting the advertised time first gets a pending acknowledge
// [RQ14] advertised execution time never exceeds 300 ms
// [RQ15] a read of the response time register completes well within 50 ms
// [RQ16] manifest pointer returns the 64-bit start address of the file table
// [RQ17] tech map pointer returns that map's 64-bit start, present only with bit 9
// [RQ18] access to an absent conditionally present register returns bad address status
// [RQ19] string registers use the encoding reported in the capability field
// [RQ20] all four registers are read-only; writes leave contents unchanged
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BCR_ADDR_W 16
`define BCR_OFS_CAP_LO 16'h01C4
`define BCR_OFS_CAP_HI 16'h01C8
`define BCR_OFS_RESP_TIME 16'h01CC
`define BCR_OFS_MAN_LO 16'h01D0
`define BCR_OFS_MAN_HI 16'h01D4
`define BCR_OFS_TECH_LO 16'h01D8
`define BCR_OFS_TECH_HI 16'h01DC
`define BCR_OFS_EXEC_CTRL 16'h0240
`define BCR_OFS_EXEC_STAT 16'h0244
`define BCR_OFS_LAST_EXEC 16'h0248

// ----------------------------------------
// capability field layout
// ----------------------------------------
`define BCR_CAP_NAME_BIT 0
`define BCR_CAP_KEEPALIVE_BIT 1
`define BCR_CAP_MSGCHAN_BIT 2
`define BCR_CAP_TIMECNT_BIT 3
`define BCR_CAP_ENC_LSB 4
`define BCR_CAP_ENC_W 4
`define BCR_CAP_FAMILY_BIT 8
`define BCR_CAP_TECHMAP_BIT 9
`define BCR_CAP_ENDIAN_BIT 10
`define BCR_CAP_WLEN_BIT 11
`define BCR_CAP_MULTIEV_BIT 12
`define BCR_CAP_USED_W 13
`define BCR_ENC_ASCII 4'h0
`define BCR_ENC_UTF8 4'h1
`define BCR_ENC_UTF16 4'h2

// ----------------------------------------
// control fields, reset values, bus answers
// ----------------------------------------
`define BCR_CTRL_PEND_EN_BIT 0
`define BCR_CTRL_CLR_CNT_BIT 1
`define BCR_CTRL_STORE_MASK 32'h0000_0001
`define BCR_CTRL_RST 32'h0000_0001
`define BCR_RESP_OKAY 2'h0
`define BCR_RESP_SLVERR 2'h2
`define BCR_RESP_DECERR 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define BCR_CLK_PERIOD_NS 50
`define BCR_MS_NS 1000000
`define BCR_MS_CYCLES (`BCR_MS_NS / `BCR_CLK_PERIOD_NS)
`define BCR_RESP_LIMIT_MS 300
`define BCR_READ_LIMIT_MS 50

`endif

/* File: rtl/bcr_pkg.sv */
// types and shared address decode of the capability block
`include "bcr_consts.svh"

package bcr_pkg;

  typedef enum logic [1:0] {
    bcr_st_idle,
    bcr_st_run,
    bcr_st_pend
  } bcr_exec_state_t;

  typedef struct packed {
    logic aw_held;
    logic [`BCR_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] ctrl;
    bcr_exec_state_t exec;
    logic [31:0] presc;
    logic [31:0] since_ack_ms;
    logic [31:0] elapsed_ms;
    logic [31:0] last_exec_ms;
    logic [15:0] pend_cnt;
    logic pend_pulse;
  } bcr_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } bcr_rom_state_t;

  // answer code for one word address; absent map pointer gives bad address status
  function automatic logic [1:0] bcr_decode(input logic [`BCR_ADDR_W-1:0] addr,
                                            input logic tech_present);
    logic [`BCR_ADDR_W-1:0] wa;
    logic [1:0] resp;
    wa = {addr[`BCR_ADDR_W-1:2], 2'h0};
    if (wa == `BCR_OFS_CAP_LO || wa == `BCR_OFS_CAP_HI) begin
      resp = `BCR_RESP_OKAY;
    end else if (wa == `BCR_OFS_RESP_TIME) begin
      resp = `BCR_RESP_OKAY;
    end else if (wa == `BCR_OFS_MAN_LO || wa == `BCR_OFS_MAN_HI) begin
      resp = `BCR_RESP_OKAY;
    end else if (wa == `BCR_OFS_TECH_LO || wa == `BCR_OFS_TECH_HI) begin
      resp = tech_present ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR; // [RQ18]
    end else if (wa == `BCR_OFS_EXEC_CTRL || wa == `BCR_OFS_EXEC_STAT) begin
      resp = `BCR_RESP_OKAY;
    end else if (wa == `BCR_OFS_LAST_EXEC) begin
      resp = `BCR_RESP_OKAY;
    end else begin
      resp = `BCR_RESP_DECERR;
    end
    return resp;
  endfunction

endpackage

/* File: rtl/bcr_read_mux.sv */
// registered read-data selector of the capability block
`timescale 1ns/1ps
`default_nettype none
`include "bcr_consts.svh"

module bcr_read_mux (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire logic [`BCR_ADDR_W-1:0] rd_addr,
  input wire logic [63:0] cap_word,
  input wire logic [31:0] resp_time,
  input wire logic [63:0] manifest_addr,
  input wire logic [63:0] tech_addr,
  input wire logic tech_present,
  input wire logic [31:0] ctrl_word,
  input wire logic [31:0] stat_word,
  input wire logic [31:0] last_word,
  output logic [31:0] rd_data,
  output logic [1:0] rd_resp
);
  import bcr_pkg::*;

  bcr_rom_state_t st_ff;
  bcr_rom_state_t nxt_st;
  logic [`BCR_ADDR_W-1:0] wa;

  // ----------------------------------------
  // word select, low word at the lower address
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    wa = {rd_addr[`BCR_ADDR_W-1:2], 2'h0};
    if (rd_en) begin
      nxt_st.resp = bcr_decode(rd_addr, tech_present);
      if (wa == `BCR_OFS_CAP_LO) begin
        nxt_st.data = cap_word[31:0];
      end else if (wa == `BCR_OFS_CAP_HI) begin
        nxt_st.data = cap_word[63:32];
      end else if (wa == `BCR_OFS_RESP_TIME) begin
        nxt_st.data = resp_time; // [RQ12] [RQ15]
      end else if (wa == `BCR_OFS_MAN_LO) begin
        nxt_st.data = manifest_addr[31:0]; // [RQ16]
      end else if (wa == `BCR_OFS_MAN_HI) begin
        nxt_st.data = manifest_addr[63:32];
      end else if (wa == `BCR_OFS_TECH_LO && tech_present) begin
        nxt_st.data = tech_addr[31:0]; // [RQ17]
      end else if (wa == `BCR_OFS_TECH_HI && tech_present) begin
        nxt_st.data = tech_addr[63:32];
      end else if (wa == `BCR_OFS_EXEC_CTRL) begin
        nxt_st.data = ctrl_word;
      end else if (wa == `BCR_OFS_EXEC_STAT) begin
        nxt_st.data = stat_word;
      end else if (wa == `BCR_OFS_LAST_EXEC) begin
        nxt_st.data = last_word;
      end else begin
        // no data leaks out with an error answer
        nxt_st.data = 32'h0000_0000; // [RQ18]
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.data;
  assign rd_resp = st_ff.resp;

endmodule

`default_nettype wire

/* File: rtl/bcr_top.sv */
// capability register bank with axi4-lite slave and command pending monitor
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_consts.svh"

module bcr_top #(
  parameter bit HAS_USER_NAME = 1'b0,
  parameter bit HAS_KEEPALIVE = 1'b0,
  parameter bit HAS_MSG_CHAN = 1'b0,
  parameter bit HAS_TIME_COUNTER = 1'b0,
  parameter logic [3:0] STR_ENCODING = `BCR_ENC_ASCII,
  parameter bit HAS_FAMILY_NAME = 1'b0,
  parameter bit HAS_TECH_MAP = 1'b1,
  parameter bit HAS_BYTE_ORDER_REG = 1'b0,
  parameter bit HAS_WRITTEN_LEN = 1'b1,
  parameter bit HAS_MULTI_EVENT = 1'b0,
  parameter logic [31:0] MAX_RESP_MS = 32'h0000_0064,
  parameter logic [63:0] MANIFEST_ADDR = 64'h0000_0000_0001_0000,
  parameter logic [63:0] TECH_MAP_ADDR = 64'h0000_0000_0002_0000,
  parameter int MS_CYCLES = `BCR_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`BCR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`BCR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_start,
  input wire logic cmd_done,
  output logic pending_ack,
  output logic cmd_busy,
  output logic [3:0] string_encoding
);
  import bcr_pkg::*;

  // ----------------------------------------
  // fixed register contents
  // ----------------------------------------
  // reserved encodings fall back to ascii rather than ever being reported
  localparam logic [3:0] ENC_SAFE = (STR_ENCODING > `BCR_ENC_UTF16) ?
                                    `BCR_ENC_ASCII : STR_ENCODING; // [RQ5]
  localparam logic [31:0] RESP_LIMIT = 32'(`BCR_RESP_LIMIT_MS);
  // clamp to the ceiling and keep at least one ms so the monitor can fire
  localparam logic [31:0] RESP_MS_EFF = (MAX_RESP_MS > RESP_LIMIT) ? RESP_LIMIT :
                                        ((MAX_RESP_MS == 32'h0000_0000) ?
                                         32'h0000_0001 : MAX_RESP_MS); // [RQ14]
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  logic [`BCR_CAP_USED_W-1:0] cap_used;
  logic [63:0] cap_word;
  logic [31:0] stat_word;

  assign cap_used[`BCR_CAP_NAME_BIT] = HAS_USER_NAME; // [RQ1]
  assign cap_used[`BCR_CAP_KEEPALIVE_BIT] = HAS_KEEPALIVE; // [RQ2]
  assign cap_used[`BCR_CAP_MSGCHAN_BIT] = HAS_MSG_CHAN; // [RQ3]
  assign cap_used[`BCR_CAP_TIMECNT_BIT] = HAS_TIME_COUNTER; // [RQ4]
  assign cap_used[`BCR_CAP_ENC_LSB +: `BCR_CAP_ENC_W] = ENC_SAFE; // [RQ5]
  assign cap_used[`BCR_CAP_FAMILY_BIT] = HAS_FAMILY_NAME; // [RQ6]
  assign cap_used[`BCR_CAP_TECHMAP_BIT] = HAS_TECH_MAP; // [RQ7]
  assign cap_used[`BCR_CAP_ENDIAN_BIT] = HAS_BYTE_ORDER_REG; // [RQ8]
  assign cap_used[`BCR_CAP_WLEN_BIT] = HAS_WRITTEN_LEN; // [RQ9]
  assign cap_used[`BCR_CAP_MULTIEV_BIT] = HAS_MULTI_EVENT; // [RQ10]
  assign cap_word = {{(64 - `BCR_CAP_USED_W){1'b0}}, cap_used}; // [RQ11]

  // string logic elsewhere must encode to this value
  assign string_encoding = ENC_SAFE; // [RQ19]

  // ----------------------------------------
  // state
  // ----------------------------------------
  bcr_state_t st_ff;
  bcr_state_t nxt_st;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic wr_ctrl;
  logic [31:0] ctrl_in;
  logic clr_cnt;
  logic ms_tick;
  logic due;
  logic [`BCR_ADDR_W-1:0] wa;

  // one write and one read in flight; each channel refuses while its answer stands
  assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  assign wa = {st_ff.aw_addr[`BCR_ADDR_W-1:2], 2'h0};
  assign wr_go = st_ff.aw_held && st_ff.w_held;
  assign wr_ctrl = wr_go && (wa == `BCR_OFS_EXEC_CTRL);
  assign clr_cnt = wr_ctrl && st_ff.w_strb[0] && st_ff.w_data[`BCR_CTRL_CLR_CNT_BIT];
  // only the enable bit is stored; the clear bit never lingers
  assign ctrl_in = st_ff.w_data & `BCR_CTRL_STORE_MASK;

  assign ms_tick = (st_ff.exec != bcr_st_idle) && (st_ff.presc == MS_LAST);
  // next ms boundary reaches the advertised time since start or last pending ack
  assign due = ms_tick && ((st_ff.since_ack_ms + 32'h0000_0001) >= RESP_MS_EFF);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pend_pulse = 1'b0;

    // write address and data may come in either order
    if (aw_hs) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end

    if (wr_go) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      // read-only words answer okay and keep their value
      nxt_st.bresp = bcr_decode(st_ff.aw_addr, HAS_TECH_MAP); // [RQ18] [RQ20]
      if (wr_ctrl) begin
        for (int i = 0; i < 4; i++) begin
          if (st_ff.w_strb[i]) begin
            nxt_st.ctrl[8*i +: 8] = ctrl_in[8*i +: 8];
          end
        end
      end
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // command execution monitor
    case (st_ff.exec)
      bcr_st_idle: begin
        if (cmd_start) begin
          nxt_st.exec = bcr_st_run;
          nxt_st.presc = 32'h0000_0000;
          nxt_st.since_ack_ms = 32'h0000_0000;
          nxt_st.elapsed_ms = 32'h0000_0000;
        end
      end
      bcr_st_run, bcr_st_pend: begin
        nxt_st.presc = ms_tick ? 32'h0000_0000 : st_ff.presc + 32'h0000_0001;
        if (ms_tick) begin
          nxt_st.elapsed_ms = st_ff.elapsed_ms + 32'h0000_0001;
          nxt_st.since_ack_ms = st_ff.since_ack_ms + 32'h0000_0001;
        end
        // finishing in the same cycle needs no pending ack
        if (cmd_done) begin
          nxt_st.exec = bcr_st_idle;
          nxt_st.last_exec_ms = st_ff.elapsed_ms;
        end else if (due && st_ff.ctrl[`BCR_CTRL_PEND_EN_BIT]) begin
          nxt_st.exec = bcr_st_pend; // [RQ13]
          nxt_st.pend_pulse = 1'b1;
          nxt_st.since_ack_ms = 32'h0000_0000;
        end
      end
      default: begin
        nxt_st.exec = bcr_st_idle;
      end
    endcase

    // a pending ack in the clearing cycle still counts
    if (nxt_st.pend_pulse) begin
      nxt_st.pend_cnt = (clr_cnt ? 16'h0000 : st_ff.pend_cnt) + 16'h0001;
    end else if (clr_cnt) begin
      nxt_st.pend_cnt = 16'h0000;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ctrl <= `BCR_CTRL_RST;
      st_ff.exec <= bcr_st_idle;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign stat_word = {st_ff.pend_cnt, 14'h0000, st_ff.exec == bcr_st_pend,
                      st_ff.exec != bcr_st_idle};

  // answer one cycle after the address is taken, far inside the read limit
  bcr_read_mux u_read_mux (
    .core_clk(core_clk),
    .rst(rst),
    .rd_en(ar_hs), // [RQ15]
    .rd_addr(s_axi_araddr),
    .cap_word(cap_word),
    .resp_time(RESP_MS_EFF), // [RQ12]
    .manifest_addr(MANIFEST_ADDR), // [RQ16]
    .tech_addr(TECH_MAP_ADDR), // [RQ17]
    .tech_present(HAS_TECH_MAP),
    .ctrl_word(st_ff.ctrl),
    .stat_word(stat_word),
    .last_word(st_ff.last_exec_ms),
    .rd_data(s_axi_rdata),
    .rd_resp(s_axi_rresp)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign pending_ack = st_ff.pend_pulse;
  assign cmd_busy = st_ff.exec != bcr_st_idle;

endmodule

`default_nettype wire

/* File: tb/bcr_top_asserts.sv */
// assertion checker of the capability register bank
`timescale 1ns/1ps
`default_nettype none
`include "bcr_consts.svh"
module bcr_top_asserts #(
  parameter bit HAS_TECH_MAP = 1'b1,
  parameter logic [31:0] MAX_RESP_MS = 32'h0000_0064,
  parameter int MS_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`BCR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [`BCR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic pending_ack,
  input wire logic cmd_busy,
  input wire logic [3:0] string_encoding
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  localparam int LMS = (MAX_RESP_MS > 300) ? 300 : ((MAX_RESP_MS == 0) ? 1 : int'(MAX_RESP_MS));
  localparam int LIM = LMS * MS_CYCLES;
  logic [15:0] ra_ff;
  logic [15:0] wa_ff;
  logic [31:0] run_ff;
  // word addresses held so answers can be tied to their request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ra_ff <= 16'h0000;
      wa_ff <= 16'h0000;
      run_ff <= 32'h0000_0000;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ra_ff <= {s_axi_araddr[15:2], 2'h0};
      if (s_axi_awvalid && s_axi_awready) wa_ff <= {s_axi_awaddr[15:2], 2'h0};
      run_ff <= (cmd_busy && !pending_ack) ? run_ff + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_CAP_HI_ZERO: assert property (s_axi_rvalid && ra_ff == `BCR_OFS_CAP_HI
    |-> s_axi_rdata == 32'h0) else $error("capability high word not zero");
  AST_CAP_LO_FIELDS: assert property (s_axi_rvalid
    && ra_ff == `BCR_OFS_CAP_LO
    |-> s_axi_rdata[31:13] == 19'h0 && s_axi_rdata[7:4] == string_encoding
    && s_axi_rdata[9] == HAS_TECH_MAP) else $error("capability low word fields wrong");
  AST_ENC_LEGAL: assert property (string_encoding <= 4'h2)
    else $error("reserved string encoding reported");
  AST_RESP_LIMIT: assert property (s_axi_rvalid && ra_ff == `BCR_OFS_RESP_TIME
    |-> s_axi_rdata == 32'(LMS) && s_axi_rdata <= 32'h0000_012C) else $error("response time wrong");
  AST_READ_PROMPT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_TECH_GATE: assert property (s_axi_rvalid && (ra_ff == `BCR_OFS_TECH_LO
    || ra_ff == `BCR_OFS_TECH_HI) |-> s_axi_rresp == (HAS_TECH_MAP ? 2'h0 : 2'h2))
    else $error("map pointer answer code wrong");
  AST_RO_WRITE: assert property ($rose(s_axi_bvalid) && wa_ff >= 16'h01C4
    && wa_ff < 16'h01D8 |-> s_axi_bresp == 2'h0) else $error("read-only write refused");
  AST_PEND_TIME: assert property (pending_ack
    |-> run_ff + 32'h2 >= LIM && run_ff <= LIM + 2) else $error("pending ack off time");
  AST_PEND_ONE: assert property (pending_ack |=> !pending_ack)
    else $error("pending ack longer than one cycle");
  cover property (pending_ack);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($rose(s_axi_bvalid));
endmodule

bind bcr_top bcr_top_asserts #(.HAS_TECH_MAP(HAS_TECH_MAP), .MAX_RESP_MS(MAX_RESP_MS),
  .MS_CYCLES(MS_CYCLES)) u_chk (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .pending_ack, .cmd_busy,
  .string_encoding);
`default_nettype wire

/* File: tb/bcr_host_model.sv */
// register bus host issuing single reads and writes
`timescale 1ns/1ps
`default_nettype none
module bcr_host_model (
  input wire logic core_clk,
  output logic [15:0] s_axi_awaddr = 16'h0000,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0] s_axi_wstrb = 4'hF,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  output logic [15:0] s_axi_araddr = 16'h0000,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  // released payload is inverted so stale values never pass
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      aw_done |= s_axi_awvalid && s_axi_awready;
      w_done |= s_axi_wvalid && s_axi_wready;
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (aw_done) s_axi_awaddr <= ~a;
      if (w_done) s_axi_wvalid <= 1'b0;
      if (w_done) s_axi_wdata <= ~d;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_bootstrap_capability_registers.sv */
// self-checking bench of the capability register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_bootstrap_capability_registers;
  localparam int MSC = 4;
  localparam logic [63:0] MAN = 64'h0000_00A5_0001_2340;
  localparam logic [63:0] TEC = 64'h0000_005A_0003_4000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_start = 1'b0;
  logic cmd_done = 1'b0;
  int errors = 0;
  int check_count = 0;
  // two builds with opposite capability sets, the second without map pointer
  for (genvar g = 0; g < 2; g++) begin : g_env
    localparam bit P = (g == 0);
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, string_encoding;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic pending_ack, cmd_busy;
    bcr_top #(.HAS_USER_NAME(P), .HAS_KEEPALIVE(!P), .HAS_MSG_CHAN(P),
      .HAS_TIME_COUNTER(!P), .STR_ENCODING(P ? 4'h2 : 4'h1), .HAS_FAMILY_NAME(P),
      .HAS_TECH_MAP(P), .HAS_BYTE_ORDER_REG(!P), .HAS_WRITTEN_LEN(P), .HAS_MULTI_EVENT(P),
      .MAX_RESP_MS(P ? 32'h0000_0003 : 32'h0000_0190), .MANIFEST_ADDR(MAN),
      .TECH_MAP_ADDR(TEC), .MS_CYCLES(MSC)) u_dut (.core_clk, .rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cmd_start, .cmd_done, .pending_ack, .cmd_busy, .string_encoding);
    bcr_host_model u_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  end
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [63:0] cap(input bit p);
    return {51'h0, p, p, !p, p, p, (p ? 4'h2 : 4'h1), !p, p, !p, p};
  endfunction
  task automatic rdc(input int e, input logic [15:0] a, input logic [31:0] xd,
                     input logic [1:0] xr);
    logic [31:0] d;
    logic [1:0] r;
    if (e == 0) g_env[0].u_host.rd(a, d, r);
    else g_env[1].u_host.rd(a, d, r);
    `CHK(r, xr)
    `CHK(d, xd)
  endtask
  task automatic wrc(input int e, input logic [15:0] a, input logic [1:0] xr);
    logic [1:0] r;
    if (e == 0) g_env[0].u_host.wr(a, 32'hFFFF_FFFF, r);
    else g_env[1].u_host.wr(a, 32'hFFFF_FFFF, r);
    `CHK(r, xr)
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int n;
    logic [63:0] cv;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      cv = cap(e == 0);
      for (int a = 'h1C4; a <= 'h1DC; a += 4) begin
        wrc(e, 16'(a), (e == 1 && a >= 'h1D8) ? 2'h2 : 2'h0);
      end
      rdc(e, 16'h01C4, cv[31:0], 2'h0);
      rdc(e, 16'h01C8, cv[63:32], 2'h0);
      rdc(e, 16'h01CC, (e == 0) ? 32'h0000_0003 : 32'h0000_012C, 2'h0);
      rdc(e, 16'h01D0, MAN[31:0], 2'h0);
      rdc(e, 16'h01D4, MAN[63:32], 2'h0);
      rdc(e, 16'h01D8, (e == 0) ? TEC[31:0] : 32'h0, (e == 0) ? 2'h0 : 2'h2);
      rdc(e, 16'h01DC, (e == 0) ? TEC[63:32] : 32'h0, (e == 0) ? 2'h0 : 2'h2);
      rdc(e, 16'h01E0, 32'h0, 2'h3);
    end
    `CHK(g_env[0].string_encoding, 4'h2)
    `CHK(g_env[1].string_encoding, 4'h1)
    // long command: pending ack after the advertised time, then again each period
    @(posedge core_clk);
    cmd_start <= 1'b1;
    @(posedge core_clk);
    cmd_start <= 1'b0;
    n = 0;
    while (g_env[0].pending_ack !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(n >= 3 * MSC && n <= 3 * MSC + 4, 1'b1)
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (g_env[0].pending_ack !== 1'b1 && n < 60);
    `CHK(n >= 3 * MSC - 1 && n <= 3 * MSC + 1, 1'b1)
    cmd_done <= 1'b1;
    @(posedge core_clk);
    cmd_done <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      if (g_env[0].pending_ack !== 1'b0) n++;
    end
    `CHK(n, 0)
    `CHK(g_env[0].cmd_busy, 1'b0)
    // two pending acks counted, six whole ms elapsed before done
    rdc(0, 16'h0244, 32'h0002_0000, 2'h0);
    rdc(0, 16'h0248, 32'h0000_0006, 2'h0);
    // all-ones write keeps the enable and clears the count
    wrc(0, 16'h0240, 2'h0);
    rdc(0, 16'h0244, 32'h0000_0000, 2'h0);
    rdc(0, 16'h0240, 32'h0000_0001, 2'h0);
    end_of_test();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
